// ==== verilog/dcs_cfg.svh ====
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

`define DCS_CLK_MHZ      250
`define DCS_T_RCD_NS     20
`define DCS_T_RP_NS      20
`define DCS_T_WR_NS      15
`define DCS_BANKS        4
`define DCS_ADDR_W       14
`define DCS_TMR_W        4
`define DCS_A10_BIT      10
`define DCS_BL_LSB       0
`define DCS_BL_MSB       2
`define DCS_BL_2         3'h1
`define DCS_BL_4         3'h2
`define DCS_BL_8         3'h3
`define DCS_EXT_SEL_BIT  14
`define DCS_DLL_OFF_BIT  0
`define DCS_MODE_RST     16'h0000

`endif

// ==== verilog/dcs_pkg.sv ====
`include "dcs_cfg.svh"

package dcs_pkg;

    typedef struct packed {
        logic                   cs_n;
        logic                   ras_n;
        logic                   cas_n;
        logic                   we_n;
        logic                   cke;
        logic [1:0]             ba;
        logic [`DCS_ADDR_W-1:0] addr;
    } dcs_pins_t;

    typedef enum logic [3:0] {
        DCS_K_DESEL,
        DCS_K_NOP,
        DCS_K_HALT,
        DCS_K_READ,
        DCS_K_STORE,
        DCS_K_ACT,
        DCS_K_PRE,
        DCS_K_REF,
        DCS_K_SELF,
        DCS_K_MODE
    } dcs_kind_t;

    typedef enum logic [3:0] {
        DCS_B_IDLE,
        DCS_B_ACTIVATING,
        DCS_B_ACTIVE,
        DCS_B_READ,
        DCS_B_STORE,
        DCS_B_READ_AC,
        DCS_B_STORE_AC,
        DCS_B_STORE_AC_RECOV,
        DCS_B_STORE_RECOV,
        DCS_B_CLOSING,
        DCS_B_REFRESHING
    } dcs_bank_t;

    typedef enum logic [1:0] {
        DCS_P_INIT,
        DCS_P_NORMAL,
        DCS_P_DOWN,
        DCS_P_SELF
    } dcs_pwr_t;

    typedef struct packed {
        logic                   valid;
        dcs_kind_t              kind;
        logic [1:0]             ba;
        logic                   auto_close;
        logic [`DCS_ADDR_W-1:0] addr;
    } dcs_cmd_t;

endpackage : dcs_pkg

// ==== verilog/dcs_cmd_decode.sv ====
`timescale 1ns/100ps
`include "dcs_cfg.svh"

module dcs_cmd_decode (
    input  wire dcs_pkg::dcs_pins_t pins_in,
    output dcs_pkg::dcs_kind_t      kind_out
);
    import dcs_pkg::*;

    function automatic dcs_kind_t decode(input dcs_pins_t p);
        dcs_kind_t k;
        k = DCS_K_DESEL;
        if (!p.cs_n) begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h7: k = DCS_K_NOP;
                3'h6: k = DCS_K_HALT;
                3'h5: k = DCS_K_READ;
                3'h4: k = DCS_K_STORE;
                3'h3: k = DCS_K_ACT;
                3'h2: k = DCS_K_PRE;
                // Same code: current CKE picks refresh or self refresh
                3'h1: k = p.cke ? DCS_K_REF : DCS_K_SELF;
                default: k = DCS_K_MODE;
            endcase
        end
        return k;
    endfunction : decode

    assign kind_out = decode(pins_in);

endmodule : dcs_cmd_decode

// ==== verilog/dcs_bank_timer.sv ====
`timescale 1ns/100ps
`include "dcs_cfg.svh"

module dcs_bank_timer #(
    parameter int W = `DCS_TMR_W
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] load_val_in,
    output logic              expired_out
);
    logic [W-1:0] count_reg;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_reg <= '0;
        end else if (load_in) begin
            count_reg <= load_val_in;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign expired_out = (count_reg == '0);

endmodule : dcs_bank_timer

// ==== verilog/dcs_state_decoder.sv ====
//Behaviour
//- CS low, RAS high, CAS low: WE picks read or store; A10 auto-close
//- Activate code opens the addressed row in the addressed bank
//- Precharge code; A10 low closes one bank, A10 high closes all
//- Burst halt ends reads without auto-close; no-op in quiet states; illegal in stores and auto-close reads
//- Mode set needs all four strobes low and every bank idle
//- Auto refresh with CKE high twice, only when every bank is idle
//- Refresh code with CKE falling enters self refresh, held by CKE low
//- Self refresh exits on CKE rise with deselect or no-op only
//- Power-down enter and exit via CKE with deselect or no-op
//- CKE rise restarts the internal clock without a sampled edge
//- Illegal applies to the bank addressed in that state, and to every bank for precharge-all and burst halt
//- Precharge to idle or closing bank is a no-op for it
//- Active bank: read or store starts burst; re-activate illegal
//- Active bank closes on precharge; refresh and mode set illegal
//- Read burst: new read restarts, precharge closes, no-op continues
//- Store burst: store restarts; read or precharge truncates it
//- Auto-close bursts run to end; all bank commands illegal
//- Closing or refreshing bank returns idle after precharge time
//- Activating bank becomes active after activate-to-column delay
//- Recovering bank without auto-close accepts a store; burst halt is a no-op; other bank commands illegal
//- BA0 low selects main mode register, BA0 high the extended one
`timescale 1ns/100ps
`include "dcs_cfg.svh"

module dcs_state_decoder (
    input  wire logic                          REF_CLK_IN,
    input  wire logic                          RESETN_IN,
    input  wire dcs_pkg::dcs_pins_t            CMD_PINS_IN,
    output dcs_pkg::dcs_cmd_t                  CMD_OUT,
    output logic                               ILLEGAL_OUT,
    output dcs_pkg::dcs_bank_t [`DCS_BANKS-1:0] BANK_STATE_OUT,
    output dcs_pkg::dcs_pwr_t                  POWER_STATE_OUT,
    output logic [15:0]                        MODE_REG_OUT,
    output logic [15:0]                        EXT_MODE_REG_OUT,
    output logic                               ALL_IDLE_OUT,
    output logic                               DLL_ON_OUT
);
    import dcs_pkg::*;

    localparam int NB  = `DCS_BANKS;
    localparam int TW  = `DCS_TMR_W;
    localparam int RCD_CYC = (`DCS_T_RCD_NS * `DCS_CLK_MHZ + 999) / 1000;
    localparam int RP_CYC  = (`DCS_T_RP_NS * `DCS_CLK_MHZ + 999) / 1000;
    localparam int WR_CYC  = (`DCS_T_WR_NS * `DCS_CLK_MHZ + 999) / 1000;
    localparam logic [TW-1:0] RCD_LD = TW'(RCD_CYC - 1);
    localparam logic [TW-1:0] RP_LD  = TW'(RP_CYC - 1);
    localparam logic [TW-1:0] WR_LD  = TW'(WR_CYC - 1);
    // Deselect with CKE low, so no false CKE rise follows reset
    localparam dcs_pins_t PIN_RST = dcs_pins_t'({4'hF, 1'b0, 2'h3,
                                                 {`DCS_ADDR_W{1'b1}}});

    dcs_pins_t              pin_meta_reg;
    dcs_pins_t              pin_sync_reg;
    logic                   cke_prev_reg;
    dcs_kind_t              kind;
    dcs_pwr_t               pwr_reg;
    dcs_pwr_t               pwr_next;
    dcs_bank_t [NB-1:0]     bank_reg;
    dcs_bank_t [NB-1:0]     bank_next;
    logic [NB-1:0]          tload;
    logic [TW-1:0]          tval [NB];
    logic [NB-1:0]          expired;
    logic [NB-1:0]          bank_ill;
    logic [NB-1:0]          hit;
    logic [NB-1:0]          close_hit;
    logic [15:0]            mode_reg;
    logic [15:0]            ext_reg;
    dcs_cmd_t               cmd_reg;
    logic                   ill_reg;
    logic                   glob_ill;
    logic                   all_idle;
    logic                   go;
    logic                   a10;
    logic                   cke_fall;
    logic                   cke_rise;
    logic                   quiet;
    logic [TW-1:0]          burst_ld;

    // Burst length in clock cycles: two data beats per cycle
    function automatic logic [TW-1:0] burst_len(input logic [2:0] bl);
        logic [TW-1:0] n;
        n = TW'(1);
        case (bl)
            `DCS_BL_4: n = TW'(2);
            `DCS_BL_8: n = TW'(4);
            default:   n = TW'(1);
        endcase
        return n - 1'b1;
    endfunction : burst_len

    function automatic dcs_bank_t burst_state(input logic st,
                                              input logic ac);
        dcs_bank_t s;
        s = DCS_B_READ;
        if (st) begin
            s = ac ? DCS_B_STORE_AC : DCS_B_STORE;
        end else begin
            s = ac ? DCS_B_READ_AC : DCS_B_READ;
        end
        return s;
    endfunction : burst_state

    // Pins come from another chip, so two flops before any decode
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pin_meta_reg <= PIN_RST;
            pin_sync_reg <= PIN_RST;
        end else begin
            pin_meta_reg <= CMD_PINS_IN;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= pin_sync_reg.cke;
        end
    end

    dcs_cmd_decode u_decode (
        .pins_in  (pin_sync_reg),
        .kind_out (kind)
    );

    assign a10      = pin_sync_reg.addr[`DCS_A10_BIT];
    assign cke_fall = cke_prev_reg && !pin_sync_reg.cke;
    assign cke_rise = !cke_prev_reg && pin_sync_reg.cke;
    assign quiet    = (kind == DCS_K_DESEL) || (kind == DCS_K_NOP);
    assign go       = (pwr_reg == DCS_P_NORMAL) && cke_prev_reg;
    assign burst_ld = burst_len(mode_reg[`DCS_BL_MSB:`DCS_BL_LSB]);

    always_comb begin
        all_idle = 1'b1;
        for (int b = 0; b < NB; b++) begin
            if (bank_reg[b] != DCS_B_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    always_comb begin
        for (int b = 0; b < NB; b++) begin
            hit[b] = go && (pin_sync_reg.ba == 2'(b));
            close_hit[b] = go && (kind == DCS_K_PRE)
                         && (hit[b] || a10);
        end
    end

    generate
        for (genvar g = 0; g < NB; g++) begin : g_timer
            dcs_bank_timer #(.W(TW)) u_timer (
                .clk_in      (REF_CLK_IN),
                .resetn_in   (RESETN_IN),
                .load_in     (tload[g]),
                .load_val_in (tval[g]),
                .expired_out (expired[g])
            );
        end
    endgenerate

    // Per-bank reaction to the current command
    always_comb begin
        for (int b = 0; b < NB; b++) begin
            bank_next[b] = bank_reg[b];
            tload[b]     = 1'b0;
            tval[b]      = '0;
            bank_ill[b]  = 1'b0;
            case (bank_reg[b])
                DCS_B_IDLE: begin
                    if (hit[b] && kind == DCS_K_ACT) begin
                        bank_next[b] = DCS_B_ACTIVATING;
                        tload[b]     = 1'b1;
                        tval[b]      = RCD_LD;
                    end else if (hit[b] && (kind == DCS_K_READ
                                 || kind == DCS_K_STORE)) begin
                        bank_ill[b] = 1'b1;
                    end else if (go && kind == DCS_K_REF
                                 && all_idle) begin
                        bank_next[b] = DCS_B_REFRESHING;
                        tload[b]     = 1'b1;
                        tval[b]      = RP_LD;
                    end
                end
                DCS_B_ACTIVATING: begin
                    if (hit[b] && !quiet && kind != DCS_K_HALT
                        || close_hit[b]) begin
                        bank_ill[b] = 1'b1;
                    end else if (expired[b]) begin
                        bank_next[b] = DCS_B_ACTIVE;
                    end
                end
                DCS_B_ACTIVE: begin
                    if (close_hit[b]) begin
                        bank_next[b] = DCS_B_CLOSING;
                        tload[b]     = 1'b1;
                        tval[b]      = RP_LD;
                    end else if (hit[b] && (kind == DCS_K_READ
                                 || kind == DCS_K_STORE)) begin
                        bank_next[b] = burst_state(
                            kind == DCS_K_STORE, a10);
                        tload[b]     = 1'b1;
                        tval[b]      = burst_ld;
                    end else if (hit[b] && kind == DCS_K_ACT) begin
                        bank_ill[b] = 1'b1;
                    end
                end
                DCS_B_READ: begin
                    if (close_hit[b]) begin
                        bank_next[b] = DCS_B_CLOSING;
                        tload[b]     = 1'b1;
                        tval[b]      = RP_LD;
                    end else if (hit[b] && kind == DCS_K_READ) begin
                        bank_next[b] = burst_state(1'b0, a10);
                        tload[b]     = 1'b1;
                        tval[b]      = burst_ld;
                    end else if (hit[b] && (kind == DCS_K_ACT
                                 || kind == DCS_K_STORE)) begin
                        bank_ill[b] = 1'b1;
                    end else if (go && kind == DCS_K_HALT) begin
                        bank_next[b] = DCS_B_ACTIVE;
                    end else if (expired[b]) begin
                        bank_next[b] = DCS_B_ACTIVE;
                    end
                end
                DCS_B_STORE: begin
                    if (close_hit[b]) begin
                        // Masking the tail data is the controller's job
                        bank_next[b] = DCS_B_CLOSING;
                        tload[b]     = 1'b1;
                        tval[b]      = RP_LD;
                    end else if (hit[b] && (kind == DCS_K_READ
                                 || kind == DCS_K_STORE)) begin
                        bank_next[b] = burst_state(
                            kind == DCS_K_STORE, a10);
                        tload[b]     = 1'b1;
                        tval[b]      = burst_ld;
                    end else if (go && kind == DCS_K_HALT
                                 || hit[b] && kind == DCS_K_ACT) begin
                        bank_ill[b] = 1'b1;
                    end else if (expired[b]) begin
                        bank_next[b] = DCS_B_STORE_RECOV;
                        tload[b]     = 1'b1;
                        tval[b]      = WR_LD;
                    end
                end
                DCS_B_READ_AC,
                DCS_B_STORE_AC,
                DCS_B_STORE_AC_RECOV: begin
                    if (hit[b] && !quiet || close_hit[b]
                        || go && kind == DCS_K_HALT) begin
                        bank_ill[b] = 1'b1;
                    end
                    if (expired[b]) begin
                        tload[b] = 1'b1;
                        if (bank_reg[b] == DCS_B_STORE_AC) begin
                            bank_next[b] = DCS_B_STORE_AC_RECOV;
                            tval[b]      = WR_LD;
                        end else begin
                            bank_next[b] = DCS_B_CLOSING;
                            tval[b]      = RP_LD;
                        end
                    end
                end
                DCS_B_STORE_RECOV: begin
                    if (hit[b] && kind == DCS_K_STORE) begin
                        bank_next[b] = burst_state(1'b1, a10);
                        tload[b]     = 1'b1;
                        tval[b]      = burst_ld;
                    end else if (hit[b] && !quiet
                                 && kind != DCS_K_HALT
                                 || close_hit[b]) begin
                        bank_ill[b] = 1'b1;
                    end else if (expired[b]) begin
                        bank_next[b] = DCS_B_ACTIVE;
                    end
                end
                default: begin
                    // Closing or refreshing; a further close is a no-op
                    if (hit[b] && (kind == DCS_K_READ
                        || kind == DCS_K_STORE
                        || kind == DCS_K_ACT)) begin
                        bank_ill[b] = 1'b1;
                    end else if (expired[b]) begin
                        bank_next[b] = DCS_B_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            for (int b = 0; b < NB; b++) begin
                bank_reg[b] <= DCS_B_IDLE;
            end
        end else begin
            bank_reg <= bank_next;
        end
    end

    // Power state: CKE alone moves it, commands only qualify the move
    always_comb begin
        pwr_next = pwr_reg;
        glob_ill = 1'b0;
        case (pwr_reg)
            DCS_P_NORMAL: begin
                if (go && (kind == DCS_K_REF || kind == DCS_K_MODE
                    || kind == DCS_K_SELF) && !all_idle) begin
                    glob_ill = 1'b1;
                end else if (cke_fall && kind == DCS_K_SELF) begin
                    pwr_next = DCS_P_SELF;
                end else if (cke_fall && quiet) begin
                    if (all_idle) begin
                        pwr_next = DCS_P_DOWN;
                    end else begin
                        glob_ill = 1'b1;
                    end
                end else if (cke_fall && all_idle
                             && kind == DCS_K_HALT) begin
                    glob_ill = 1'b1;
                end
            end
            default: begin
                // Exit acts on the first CKE-high sample, no wake-up wait
                if (cke_rise) begin
                    pwr_next = DCS_P_NORMAL;
                    glob_ill = !quiet;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pwr_reg <= DCS_P_INIT;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // Mode registers only change while every bank is idle
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mode_reg <= `DCS_MODE_RST;
            ext_reg  <= `DCS_MODE_RST;
        end else if (go && kind == DCS_K_MODE && all_idle) begin
            if (pin_sync_reg.ba[0]) begin
                ext_reg  <= {pin_sync_reg.ba, pin_sync_reg.addr};
            end else begin
                mode_reg <= {pin_sync_reg.ba, pin_sync_reg.addr};
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cmd_reg <= '0;
            ill_reg <= 1'b0;
        end else begin
            cmd_reg.valid      <= go && !quiet;
            cmd_reg.kind       <= kind;
            cmd_reg.ba         <= pin_sync_reg.ba;
            cmd_reg.auto_close <= a10;
            cmd_reg.addr       <= pin_sync_reg.addr;
            ill_reg            <= glob_ill || (|bank_ill);
        end
    end

    assign CMD_OUT          = cmd_reg;
    assign ILLEGAL_OUT      = ill_reg;
    assign BANK_STATE_OUT   = bank_reg;
    assign POWER_STATE_OUT  = pwr_reg;
    assign MODE_REG_OUT     = mode_reg;
    assign EXT_MODE_REG_OUT = ext_reg;
    assign DLL_ON_OUT       = !ext_reg[`DCS_DLL_OFF_BIT];
    // Registered view would lag the bank state by a cycle
    assign ALL_IDLE_OUT     = all_idle;

endmodule : dcs_state_decoder

// ==== tb/dcs_ctl_model.sv ====
`timescale 1ns/100ps
module dcs_ctl_model (
    input  wire dcs_pkg::dcs_kind_t kind_in,
    input  wire logic [1:0]         ba_in,
    input  wire logic [13:0]        addr_in,
    input  wire logic               cke_in,
    output dcs_pkg::dcs_pins_t      pins_out
);
    import dcs_pkg::*;
    logic [3:0] code;
    always_comb begin
        case (kind_in)
            DCS_K_NOP:   code = 4'h7;
            DCS_K_HALT:  code = 4'h6;
            DCS_K_READ:  code = 4'h5;
            DCS_K_STORE: code = 4'h4;
            DCS_K_ACT:   code = 4'h3;
            DCS_K_PRE:   code = 4'h2;
            DCS_K_REF,
            DCS_K_SELF:  code = 4'h1;
            DCS_K_MODE:  code = 4'h0;
            // Strobes low on deselect, so only cs_n can hide them
            default:     code = 4'h8;
        endcase
    end
    assign pins_out = {code, cke_in, ba_in, addr_in};
endmodule : dcs_ctl_model

// ==== tb/dcs_state_decoder_properties.sv ====
`timescale 1ns/100ps
module dcs_chk (
    input wire logic                     REF_CLK_IN,
    input wire logic                     RESETN_IN,
    input wire dcs_pkg::dcs_cmd_t        CMD_OUT,
    input wire logic                     ILLEGAL_OUT,
    input wire dcs_pkg::dcs_bank_t [3:0] BANK_STATE_OUT,
    input wire logic [15:0]              MODE_REG_OUT,
    input wire logic [15:0]              EXT_MODE_REG_OUT,
    input wire logic                     ALL_IDLE_OUT
);
    import dcs_pkg::*;
    logic [15:0] bq;
    logic        v;
    assign v = CMD_OUT.valid && !ILLEGAL_OUT;
    // Bank states as the decoded command saw them
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            bq <= '0;
        end else begin
            bq <= BANK_STATE_OUT;
        end
    end
    default clocking dc @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    a_act_opens_row: assert property (
        v && CMD_OUT.kind == DCS_K_ACT |->
        BANK_STATE_OUT[CMD_OUT.ba] == DCS_B_ACTIVATING)
        else $error("activate did not open the bank");
    a_act_on_active: assert property (
        CMD_OUT.valid && CMD_OUT.kind == DCS_K_ACT &&
        bq[{CMD_OUT.ba, 2'b00} +: 4] == DCS_B_ACTIVE |-> ILLEGAL_OUT)
        else $error("second activate not flagged");
    a_mode_needs_idle: assert property (
        CMD_OUT.valid && CMD_OUT.kind == DCS_K_MODE |->
        ILLEGAL_OUT == !$past(ALL_IDLE_OUT))
        else $error("mode set legality wrong");
    a_refresh_all: assert property (
        v && CMD_OUT.kind == DCS_K_REF |->
        BANK_STATE_OUT == {4{DCS_B_REFRESHING}})
        else $error("refresh did not reach all banks");
    a_activate_delay: assert property (
        BANK_STATE_OUT[0] == DCS_B_ACTIVATING && bq[3:0] != DCS_B_ACTIVATING
        |-> (BANK_STATE_OUT[0] == DCS_B_ACTIVATING)[*5] ##1
        BANK_STATE_OUT[0] == DCS_B_ACTIVE)
        else $error("activate delay wrong");
    a_close_time: assert property (
        BANK_STATE_OUT[0] == DCS_B_CLOSING && bq[3:0] != DCS_B_CLOSING
        |-> (BANK_STATE_OUT[0] == DCS_B_CLOSING)[*5] ##1
        BANK_STATE_OUT[0] == DCS_B_IDLE)
        else $error("precharge time wrong");
    a_close_all: assert property (
        v && CMD_OUT.kind == DCS_K_PRE && CMD_OUT.auto_close &&
        bq[3:0] == DCS_B_ACTIVE |-> BANK_STATE_OUT[0] == DCS_B_CLOSING)
        else $error("close all missed bank 0");
    a_mode_load: assert property (
        v && CMD_OUT.kind == DCS_K_MODE |->
        (CMD_OUT.ba[0] ? EXT_MODE_REG_OUT : MODE_REG_OUT) ==
        {CMD_OUT.ba, CMD_OUT.addr})
        else $error("mode register load wrong");
    c_refresh: cover property (v && CMD_OUT.kind == DCS_K_REF);
    c_illegal: cover property (ILLEGAL_OUT);
    c_close: cover property (BANK_STATE_OUT[0] == DCS_B_CLOSING);
endmodule : dcs_chk
bind dcs_state_decoder dcs_chk u_chk (.REF_CLK_IN(REF_CLK_IN),
    .RESETN_IN(RESETN_IN), .CMD_OUT(CMD_OUT), .ILLEGAL_OUT(ILLEGAL_OUT),
    .BANK_STATE_OUT(BANK_STATE_OUT), .MODE_REG_OUT(MODE_REG_OUT),
    .EXT_MODE_REG_OUT(EXT_MODE_REG_OUT), .ALL_IDLE_OUT(ALL_IDLE_OUT));

// ==== tb/dcs_state_decoder_test.sv ====
`timescale 1ns/100ps
module dcs_state_decoder_test;
    import dcs_pkg::*;
    logic            clk;
    logic            rst_n;
    logic            cke;
    logic [1:0]      ba;
    logic [13:0]     addr;
    dcs_kind_t       kind;
    dcs_pins_t       pins;
    dcs_cmd_t        cmd;
    logic            illegal;
    dcs_bank_t [3:0] bank;
    dcs_pwr_t        pwr;
    logic [15:0]     mode;
    logic [15:0]     ext;
    logic            all_idle;
    logic            dll_on;
    int              miscompares = 0;
    int              tests_run = 0;
    int              cycles = 0;
    dcs_ctl_model u_ctl (.kind_in(kind), .ba_in(ba), .addr_in(addr),
        .cke_in(cke), .pins_out(pins));
    dcs_state_decoder DUT (.REF_CLK_IN(clk), .RESETN_IN(rst_n),
        .CMD_PINS_IN(pins), .CMD_OUT(cmd), .ILLEGAL_OUT(illegal),
        .BANK_STATE_OUT(bank), .POWER_STATE_OUT(pwr), .MODE_REG_OUT(mode),
        .EXT_MODE_REG_OUT(ext), .ALL_IDLE_OUT(all_idle), .DLL_ON_OUT(dll_on));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    // Two sync flops plus one output stage: answer lands three edges late
    task automatic go(input dcs_kind_t k, input logic [1:0] b,
                      input logic [13:0] a, input logic c);
        @(posedge clk);
        kind <= k;
        ba <= b;
        addr <= a;
        cke <= c;
        @(posedge clk);
        kind <= DCS_K_NOP;
        idle(2);
    endtask : go
    task automatic t_init;
        idle(4);
        chk(pwr, DCS_P_INIT);
        go(DCS_K_NOP, 2'h0, 14'h0000, 1'b1);
        idle(2);
        chk(pwr, DCS_P_NORMAL);
        go(DCS_K_PRE, 2'h0, 14'h0400, 1'b1);
        chk(illegal, 1'b0);
        go(DCS_K_MODE, 2'h1, 14'h0001, 1'b1);
        chk(dll_on, 1'b0);
        go(DCS_K_MODE, 2'h1, 14'h0000, 1'b1);
        chk(ext, 16'h4000);
        chk(dll_on, 1'b1);
        idle(2);
        go(DCS_K_REF, 2'h0, 14'h0000, 1'b1);
        idle(2);
        go(DCS_K_REF, 2'h0, 14'h0000, 1'b1);
        chk(illegal, 1'b0);
        idle(2);
        go(DCS_K_MODE, 2'h0, 14'h0003, 1'b1);
        chk(mode, 16'h0003);
        idle(200);
    endtask : t_init
    task automatic t_rows;
        go(DCS_K_ACT, 2'h1, 14'h0000, 1'b1);
        chk(bank[1], DCS_B_ACTIVATING);
        go(DCS_K_ACT, 2'h1, 14'h0000, 1'b1);
        chk(illegal, 1'b1);
        go(DCS_K_ACT, 2'h0, 14'h0000, 1'b1);
        chk(bank[0], DCS_B_ACTIVATING);
        go(DCS_K_ACT, 2'h1, 14'h0000, 1'b1);
        chk(illegal, 1'b1);
        go(DCS_K_REF, 2'h0, 14'h0000, 1'b1);
        chk(illegal, 1'b1);
        go(DCS_K_MODE, 2'h0, 14'h0000, 1'b1);
        chk(mode, 16'h0003);
        go(DCS_K_READ, 2'h1, 14'h0008, 1'b1);
        chk(bank[1], DCS_B_READ);
        go(DCS_K_PRE, 2'h3, 14'h0400, 1'b1);
        chk(bank, {DCS_B_IDLE, DCS_B_IDLE, DCS_B_CLOSING, DCS_B_CLOSING});
        idle(5);
        chk(all_idle, 1'b1);
    endtask : t_rows
    task automatic t_refresh;
        go(DCS_K_REF, 2'h0, 14'h0000, 1'b1);
        chk(bank, {4{DCS_B_REFRESHING}});
        chk(cmd.kind, DCS_K_REF);
        idle(5);
        chk(all_idle, 1'b1);
    endtask : t_refresh
    task automatic t_auto;
        go(DCS_K_ACT, 2'h2, 14'h0000, 1'b1);
        idle(5);
        go(DCS_K_READ, 2'h2, 14'h0400, 1'b1);
        chk(bank[2], DCS_B_READ_AC);
        go(DCS_K_ACT, 2'h2, 14'h0000, 1'b1);
        chk(illegal, 1'b1);
        idle(12);
        go(DCS_K_ACT, 2'h2, 14'h0000, 1'b1);
        idle(5);
        go(DCS_K_STORE, 2'h2, 14'h0400, 1'b1);
        chk(bank[2], DCS_B_STORE_AC);
        go(DCS_K_PRE, 2'h2, 14'h0000, 1'b1);
        chk(illegal, 1'b1);
        go(DCS_K_HALT, 2'h0, 14'h0000, 1'b1);
        chk(illegal, 1'b1);
        idle(16);
        chk(all_idle, 1'b1);
    endtask : t_auto
    task automatic t_power;
        go(DCS_K_SELF, 2'h0, 14'h0000, 1'b0);
        chk(pwr, DCS_P_SELF);
        idle(10);
        chk(pwr, DCS_P_SELF);
        go(DCS_K_NOP, 2'h0, 14'h0000, 1'b1);
        idle(2);
        chk(pwr, DCS_P_NORMAL);
        idle(17);
        go(DCS_K_NOP, 2'h0, 14'h0000, 1'b0);
        chk(pwr, DCS_P_DOWN);
        go(DCS_K_DESEL, 2'h0, 14'h0000, 1'b1);
        idle(2);
        chk(pwr, DCS_P_NORMAL);
    endtask : t_power
    task automatic wrap_up;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        rst_n = 1'b0;
        cke = 1'b0;
        kind = DCS_K_DESEL;
        ba = 2'h0;
        addr = 14'h0000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_init();
        t_rows();
        t_refresh();
        t_auto();
        t_power();
        wrap_up();
    end
endmodule : dcs_state_decoder_test
